//--- logic/eisc_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Host writing one clears flag; zero keeps.
// - Software enable rising sets bit 31.
// - Stop command plus transmitter halted sets 25.
// - Receive engine halted sets bit 24.
// - Dropped counter crossing midpoint sets 23.
// - Notify-marked buffer fully loaded sets 21.
// - Programmed receive transfer count done sets 20.
// - Timer wrapping past zero sets 19.
// - Bit 18 mirrors physical layer, read-only.
// - Power event sets 17, independent of wake.
// - Only byte test write wakes device.
// - Power event flag bypasses deassertion hold-off.
// - Transmit status FIFO overflow sets 16.
// - Received packet over 2048 bytes sets 15.
// - Receive error condition sets bit 14.
// - Transmit error condition sets bit 13.
// - Write into full transmit FIFO sets 10.
// - Free space above threshold sets bit 9.
// - Status FIFOs becoming full set 8, 4.
// - Status levels exceeding threshold set 7, 3.
// - Discarded receive frame sets bit 6.
// - Three pin events in bits 2-0.
// - Flags latch regardless of enable mask.
// - Master request is any enabled flag.
module eisc_top
  import eisc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rdata_oe_n,
  input wire logic [31:0] event_enable,
  input wire logic stop_tx_command,
  input wire logic transmitter_halted,
  input wire logic receiver_halted,
  input wire logic dropped_count_inc,
  input wire logic [31:0] dropped_count,
  input wire logic buffer_loaded,
  input wire logic completion_notify_marker,
  input wire logic receive_transfer_load,
  input wire logic [11:0] receive_transfer_count,
  input wire logic receive_unit_taken,
  input wire logic timer_tick,
  input wire logic [15:0] timer_count,
  input wire logic physical_layer_event,
  input wire logic power_event,
  input wire logic low_power_active,
  input wire logic tx_status_overflow,
  input wire logic rx_packet_done,
  input wire logic [11:0] rx_packet_bytes,
  input wire logic receive_error,
  input wire logic transmit_error,
  input wire logic tx_data_write,
  input wire logic tx_data_full,
  input wire logic [7:0] tx_free_blocks,
  input wire logic [7:0] tx_space_threshold,
  input wire logic tx_status_full,
  input wire logic [7:0] tx_status_used,
  input wire logic [7:0] tx_status_threshold,
  input wire logic rx_status_full,
  input wire logic [7:0] rx_status_used,
  input wire logic [7:0] rx_status_threshold,
  input wire logic frame_dropped,
  input wire logic [2:0] pin_events,
  output logic [31:0] event_flags,
  output logic master_request,
  output logic power_event_direct,
  output logic wake_request
);

  eisc_flag_if flag_bus ();

  logic rx_transfer_done;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] view;

  // Previous values for the conditions that set a flag on their rising edge.
  logic [5:0] prev_d;
  logic [5:0] prev_q;
  logic [5:0] cond;

  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic oe_n_d;
  logic oe_n_q;
  logic wake_d;
  logic wake_q;

  logic wr_lo;
  logic wr_hi;
  logic rd_lo;
  logic rd_hi;
  logic wr_byte_test;

  logic soft_req_set;
  logic tx_halt_set;
  logic rx_halt_set;
  logic drop_mid_set;
  logic buf_notify_set;
  logic timer_wrap_set;
  logic power_set;
  logic tx_ovf_set;
  logic rx_long_set;
  logic rx_err_set;
  logic tx_err_set;
  logic tx_overrun_set;
  logic tx_space_set;
  logic tx_full_set;
  logic rx_full_set;
  logic tx_level_set;
  logic rx_level_set;
  logic drop_frame_set;
  logic [2:0] pin_set;

  eisc_xfer_counter u_xfer (
    .mclk(mclk),
    .resetn(resetn),
    .load(receive_transfer_load),
    .count(receive_transfer_count),
    .unit_taken(receive_unit_taken),
    .done(rx_transfer_done)
  );

  eisc_flag_bank #(
    .MASK(WRITABLE_MASK)
  ) u_bank (
    .mclk(mclk),
    .resetn(resetn),
    .flags(flag_bus)
  );

  // One decode for the write strobes; other addresses select nothing.
  always_comb begin
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_byte_test = 1'b0;
    if (host_cs && host_wr) begin
      case (host_addr)
        EVENT_FLAGS_LO_OFS: begin
          wr_lo = 1'b1;
        end
        EVENT_FLAGS_HI_OFS: begin
          wr_hi = 1'b1;
        end
        BYTE_TEST_LO_OFS, BYTE_TEST_HI_OFS: begin
          wr_byte_test = 1'b1;
        end
        default: begin
          wr_lo = 1'b0;
        end
      endcase
    end
  end

  assign rd_lo = host_cs && host_rd && host_addr == EVENT_FLAGS_LO_OFS;
  assign rd_hi = host_cs && host_rd && host_addr == EVENT_FLAGS_HI_OFS;

  always_comb begin
    cond = 6'h00;
    cond[0] = event_enable[SOFTWARE_REQUEST_BIT];
    cond[1] = stop_tx_command && transmitter_halted;
    cond[2] = tx_status_full;
    cond[3] = rx_status_full;
    cond[4] = tx_status_used > tx_status_threshold;
    cond[5] = rx_status_used > rx_status_threshold;
  end

  always_comb begin
    prev_d = cond;
  end

  // One strobe per source keeps each set condition on a line of its own.
  always_comb begin
    soft_req_set = cond[0] && !prev_q[0];
    tx_halt_set = cond[1] && !prev_q[1];
    rx_halt_set = receiver_halted;
    drop_mid_set = dropped_count_inc &&
      dropped_count == DROPPED_MIDPOINT_VALUE;
    buf_notify_set = buffer_loaded && completion_notify_marker;
    timer_wrap_set = timer_tick &&
      timer_count == TIMER_ZERO_VALUE;
    power_set = power_event;
    tx_ovf_set = tx_status_overflow;
    rx_long_set = rx_packet_done &&
      rx_packet_bytes > RECEIVE_WATCHDOG_BYTES;
    rx_err_set = receive_error;
    tx_err_set = transmit_error;
    tx_overrun_set = tx_data_write && tx_data_full;
    tx_space_set = tx_free_blocks > tx_space_threshold;
    tx_full_set = cond[2] && !prev_q[2];
    rx_full_set = cond[3] && !prev_q[3];
    tx_level_set = cond[4] && !prev_q[4];
    rx_level_set = cond[5] && !prev_q[5];
    drop_frame_set = frame_dropped;
    pin_set = pin_events;
  end

  // Every source sets its flag whatever the enable mask says.
  always_comb begin
    set_v = 32'h0000_0000;
    set_v[SOFTWARE_REQUEST_BIT] = soft_req_set;
    set_v[TRANSMIT_HALTED_BIT] = tx_halt_set;
    set_v[RECEIVE_HALTED_BIT] = rx_halt_set;
    set_v[DROPPED_MIDPOINT_BIT] = drop_mid_set;
    set_v[BUFFER_LOADED_BIT] = buf_notify_set;
    set_v[RX_TRANSFER_DONE_BIT] = rx_transfer_done;
    set_v[TIMER_WRAP_BIT] = timer_wrap_set;
    set_v[POWER_EVENT_BIT] = power_set;
    set_v[TX_STATUS_OVERFLOW_BIT] = tx_ovf_set;
    set_v[RECEIVE_WATCHDOG_BIT] = rx_long_set;
    set_v[RECEIVE_ERROR_BIT] = rx_err_set;
    set_v[TRANSMIT_ERROR_BIT] = tx_err_set;
    set_v[TX_DATA_OVERRUN_BIT] = tx_overrun_set;
    set_v[TX_SPACE_AVAILABLE_BIT] = tx_space_set;
    set_v[TX_STATUS_FULL_BIT] = tx_full_set;
    set_v[RX_STATUS_FULL_BIT] = rx_full_set;
    set_v[TX_STATUS_LEVEL_BIT] = tx_level_set;
    set_v[RX_STATUS_LEVEL_BIT] = rx_level_set;
    set_v[FRAME_DROPPED_BIT] = drop_frame_set;
    set_v[PIN_EVENT_LSB +: PIN_EVENT_COUNT] = pin_set;
  end

  // Each half of the word is acknowledged by its own 16-bit write.
  always_comb begin
    clr_v = 32'h0000_0000;
    if (wr_lo) begin
      clr_v[15:0] = host_wdata;
    end
    if (wr_hi) begin
      clr_v[31:16] = host_wdata;
    end
  end

  assign flag_bus.set = set_v;
  assign flag_bus.clr = clr_v;

  // The physical layer bit is never stored here, so host writes miss it.
  always_comb begin
    view = flag_bus.q;
    view[PHYSICAL_LAYER_BIT] = physical_layer_event;
  end

  always_comb begin
    rdata_d = rdata_q;
    oe_n_d = 1'b1;
    if (rd_lo) begin
      rdata_d = view[15:0];
      oe_n_d = 1'b0;
    end else if (rd_hi) begin
      rdata_d = view[31:16];
      oe_n_d = 1'b0;
    end else if (host_cs && host_rd) begin
      rdata_d = 16'h0000;
      oe_n_d = 1'b0;
    end
  end

  // A power event never wakes the part; only a byte test write does.
  always_comb begin
    wake_d = wr_byte_test && low_power_active;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 6'h00;
    end else begin
      prev_q <= prev_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
      oe_n_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      oe_n_q <= oe_n_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign host_rdata = rdata_q;
  assign host_rdata_oe_n = oe_n_q;
  assign event_flags = view;
  assign master_request = |(view & event_enable);
  // Kept apart from the hold-off path so the pin driver can pass it at once.
  assign power_event_direct = view[POWER_EVENT_BIT] &&
    event_enable[POWER_EVENT_BIT];
  assign wake_request = wake_q;

endmodule

//--- logic/eisc_pkg.sv
package eisc_pkg;

  // Host bus byte offsets of the 16-bit halves.
  localparam logic [7:0] EVENT_FLAGS_LO_OFS = 8'h58;
  localparam logic [7:0] EVENT_FLAGS_HI_OFS = 8'h5a;
  localparam logic [7:0] BYTE_TEST_LO_OFS = 8'h64;
  localparam logic [7:0] BYTE_TEST_HI_OFS = 8'h66;

  // Flag positions within event_flags.
  localparam int SOFTWARE_REQUEST_BIT = 31;
  localparam int TRANSMIT_HALTED_BIT = 25;
  localparam int RECEIVE_HALTED_BIT = 24;
  localparam int DROPPED_MIDPOINT_BIT = 23;
  localparam int BUFFER_LOADED_BIT = 21;
  localparam int RX_TRANSFER_DONE_BIT = 20;
  localparam int TIMER_WRAP_BIT = 19;
  localparam int PHYSICAL_LAYER_BIT = 18;
  localparam int POWER_EVENT_BIT = 17;
  localparam int TX_STATUS_OVERFLOW_BIT = 16;
  localparam int RECEIVE_WATCHDOG_BIT = 15;
  localparam int RECEIVE_ERROR_BIT = 14;
  localparam int TRANSMIT_ERROR_BIT = 13;
  localparam int TX_DATA_OVERRUN_BIT = 10;
  localparam int TX_SPACE_AVAILABLE_BIT = 9;
  localparam int TX_STATUS_FULL_BIT = 8;
  localparam int TX_STATUS_LEVEL_BIT = 7;
  localparam int FRAME_DROPPED_BIT = 6;
  localparam int RX_STATUS_FULL_BIT = 4;
  localparam int RX_STATUS_LEVEL_BIT = 3;
  localparam int PIN_EVENT_LSB = 0;
  localparam int PIN_EVENT_COUNT = 3;

  // Bits that hardware sets and software clears by writing one.
  localparam logic [31:0] WRITABLE_MASK = 32'h83bb_e7df;
  localparam logic [31:0] EVENT_FLAGS_RESET = 32'h0000_0000;

  localparam logic [31:0] DROPPED_MIDPOINT_VALUE = 32'h7fff_ffff;
  localparam logic [15:0] TIMER_ZERO_VALUE = 16'h0000;
  localparam logic [11:0] RECEIVE_WATCHDOG_BYTES = 12'h800;
  localparam logic [11:0] TRANSFER_COUNT_ZERO = 12'h000;

  typedef enum logic [1:0] {
    EISC_XFER_IDLE = 2'b01,
    EISC_XFER_BUSY = 2'b10
  } eisc_xfer_state_t;

endpackage

//--- logic/eisc_flag_if.sv
`timescale 1ns/100ps
interface eisc_flag_if;
  logic [31:0] set;
  logic [31:0] clr;
  logic [31:0] q;
  modport ctrl (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface

//--- logic/eisc_flag_bank.sv
`timescale 1ns/100ps
module eisc_flag_bank
  import eisc_pkg::*;
#(
  parameter logic [31:0] MASK = 32'hffff_ffff
) (
  input wire logic mclk,
  input wire logic resetn,
  eisc_flag_if.bank flags
);

  logic [31:0] flags_d;
  logic [31:0] flags_q;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    flags_d = ((flags_q & ~flags.clr) | flags.set) & MASK;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= EVENT_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags.q = flags_q;

endmodule

//--- logic/eisc_xfer_counter.sv
`timescale 1ns/100ps
module eisc_xfer_counter
  import eisc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [11:0] count,
  input wire logic unit_taken,
  output logic done
);

  eisc_xfer_state_t state_d;
  eisc_xfer_state_t state_q;
  logic [11:0] left_d;
  logic [11:0] left_q;
  logic done_d;
  logic done_q;

  // A zero count arms nothing; a fresh load restarts the run at once.
  always_comb begin
    state_d = state_q;
    left_d = left_q;
    done_d = 1'b0;
    case (state_q)
      EISC_XFER_IDLE: begin
        if (load && count != TRANSFER_COUNT_ZERO) begin
          state_d = EISC_XFER_BUSY;
          left_d = count;
        end
      end
      EISC_XFER_BUSY: begin
        if (load) begin
          left_d = count;
          if (count == TRANSFER_COUNT_ZERO) begin
            state_d = EISC_XFER_IDLE;
          end
        end else if (unit_taken) begin
          left_d = left_q - 12'h001;
          if (left_q == 12'h001) begin
            state_d = EISC_XFER_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = EISC_XFER_IDLE;
        left_d = TRANSFER_COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= EISC_XFER_IDLE;
      left_q <= TRANSFER_COUNT_ZERO;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule

//--- verification/eisc_top_properties.sv
`timescale 1ns/100ps
module eisc_top_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_rdata_oe_n,
  input wire logic [31:0] event_enable,
  input wire logic receive_error,
  input wire logic physical_layer_event,
  input wire logic low_power_active,
  input wire logic [31:0] event_flags,
  input wire logic master_request,
  input wire logic power_event_direct,
  input wire logic wake_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_rd_lo; host_cs && host_rd && host_addr == 8'h58; endsequence
  sequence s_wr_lo; host_cs && host_wr && host_addr == 8'h58; endsequence
  sequence s_wake;
    host_cs && host_wr && (host_addr == 8'h64 || host_addr == 8'h66);
  endsequence
  property p_master; master_request == |(event_flags & event_enable);
  endproperty
  property p_direct;
    power_event_direct == (event_flags[17] && event_enable[17]);
  endproperty
  property p_phy; event_flags[18] == physical_layer_event; endproperty
  property p_reserved; (event_flags & 32'h7c40_1820) == 32'h0; endproperty
  property p_err_set; receive_error |=> event_flags[14]; endproperty
  property p_clear;
    s_wr_lo ##0 (host_wdata[14] && !receive_error) |=> !event_flags[14];
  endproperty
  property p_keep;
    event_flags[14] && !(host_wr && host_wdata[14]) |=> event_flags[14];
  endproperty
  property p_read;
    s_rd_lo |=> !host_rdata_oe_n && host_rdata == $past(event_flags[15:0]);
  endproperty
  property p_wake; s_wake ##0 low_power_active |=> wake_request; endproperty
  property p_wake_cause;
    wake_request |-> $past(host_cs && host_wr && low_power_active &&
      (host_addr == 8'h64 || host_addr == 8'h66));
  endproperty
  a_master: assert property (p_master) else $error("master_request");
  a_direct: assert property (p_direct) else $error("direct");
  a_phy: assert property (p_phy) else $error("phy mirror");
  a_reserved: assert property (p_reserved) else $error("reserved");
  a_err_set: assert property (p_err_set) else $error("rx error");
  a_clear: assert property (p_clear) else $error("clear");
  a_keep: assert property (p_keep) else $error("keep");
  a_read: assert property (p_read) else $error("read data");
  a_wake: assert property (p_wake) else $error("wake");
  a_wake_cause: assert property (p_wake_cause) else $error("wake");
endmodule
bind eisc_top eisc_top_properties eisc_top_properties_i (.mclk, .resetn,
  .host_cs, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata,
  .host_rdata_oe_n, .event_enable, .receive_error, .physical_layer_event,
  .low_power_active, .event_flags, .master_request, .power_event_direct,
  .wake_request);

//--- verification/eisc_host_model.sv
`timescale 1ns/100ps
module eisc_host_model (
  input wire logic mclk,
  output logic host_cs,
  output logic host_rd,
  output logic host_wr,
  output logic [7:0] host_addr,
  output logic [15:0] host_wdata
);
  // Idle lines are inverted so a stale value is never mistaken for data.
  task automatic idle();
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask
  // Called on a falling edge. One idle cycle comes first, so a strobe is
  // never lowered and raised again in the same step.
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    @(negedge mclk);
    host_cs = 1'b1;
    host_rd = !w;
    host_wr = w;
    host_addr = a;
    host_wdata = d;
    @(negedge mclk);
    idle();
  endtask
  initial begin
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'hff;
    host_wdata = 16'hffff;
  end
endmodule

//--- verification/eisc_top_tb.sv
`timescale 1ns/100ps
module eisc_top_tb;
  logic mclk, resetn, host_cs, host_rd, host_wr, host_rdata_oe_n, q;
  logic [7:0] host_addr;
  logic [15:0] host_wdata, host_rdata;
  logic [31:0] event_enable, event_flags, p;
  logic master_request, power_event_direct, wake_request;
  logic physical_layer_event, low_power_active, receive_transfer_load;
  logic receive_unit_taken;
  logic [11:0] receive_transfer_count;
  wire [31:0] dropped_count = {!q, {31{q}}};
  int n_errors, check_count;
  eisc_host_model eisc_host_model_i (.mclk, .host_cs, .host_rd, .host_wr,
    .host_addr, .host_wdata);
  eisc_top eisc_top_i (.mclk, .resetn, .host_cs, .host_rd, .host_wr,
    .host_addr, .host_wdata, .host_rdata, .host_rdata_oe_n, .event_enable,
    .stop_tx_command(p[25]), .transmitter_halted(p[25]),
    .receiver_halted(p[24]), .dropped_count_inc(p[23]), .dropped_count,
    .buffer_loaded(p[21]), .completion_notify_marker(q),
    .receive_transfer_load, .receive_transfer_count, .receive_unit_taken,
    .timer_tick(p[19]), .timer_count({15'h0, !q}), .physical_layer_event,
    .power_event(p[17]), .low_power_active, .tx_status_overflow(p[16]),
    .rx_packet_done(p[15]), .rx_packet_bytes({4'h8, 7'h00, q}),
    .receive_error(p[14]), .transmit_error(p[13]), .tx_data_write(p[10]),
    .tx_data_full(q), .tx_free_blocks({7'h00, p[9]}),
    .tx_space_threshold(8'h00), .tx_status_full(p[8]),
    .tx_status_used({7'h00, p[7]}), .tx_status_threshold(8'h00),
    .rx_status_full(p[4]), .rx_status_used({7'h00, p[3]}),
    .rx_status_threshold(8'h00), .frame_dropped(p[6]),
    .pin_events(p[2:0]), .event_flags, .master_request,
    .power_event_direct, .wake_request);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    eisc_host_model_i.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    eisc_host_model_i.acc(1'b0, a, 16'h0000);
    chk("read data", e, host_rdata);
    chk("read enable", 16'h0000, {15'h0, host_rdata_oe_n});
  endtask
  task automatic t_flag(input int b, input logic qv, input logic hit);
    logic [7:0] a;
    logic [15:0] m;
    a = b > 15 ? 8'h5a : 8'h58;
    m = 16'h0001 << (b % 16);
    q = qv;
    p[b] = 1'b1;
    @(negedge mclk);
    p = 32'h0;
    chk("master_request", 16'h0000, {15'h0, master_request});
    rd(a, hit ? m : 16'h0000);
    wr(a, m);
    rd(a, 16'h0000);
  endtask
  task automatic t_sources();
    int h[$] = '{25, 24, 23, 21, 19, 17, 16};
    int la[$] = '{15, 14, 13, 10, 9};
    int lb[$] = '{8, 7, 6, 4, 3, 2, 1, 0};
    int gated[$] = '{23, 21, 19, 15, 10};
    foreach (h[i]) t_flag(h[i], 1'b1, 1'b1);
    foreach (la[i]) t_flag(la[i], 1'b1, 1'b1);
    foreach (lb[i]) t_flag(lb[i], 1'b1, 1'b1);
    foreach (gated[i]) t_flag(gated[i], 1'b0, 1'b0);
    q = 1'b1;
  endtask
  task automatic t_misc();
    rd(8'h58, 16'h0000);
    rd(8'h5a, 16'h0000);
    rd(8'h70, 16'h0000);
    physical_layer_event = 1'b1;
    wr(8'h5a, 16'h0004);
    rd(8'h5a, 16'h0004);
    physical_layer_event = 1'b0;
    rd(8'h5a, 16'h0000);
    event_enable[31] = 1'b1;
    @(negedge mclk);
    chk("master_request", 16'h0001, {15'h0, master_request});
    rd(8'h5a, 16'h8000);
    wr(8'h5a, 16'h8000);
    rd(8'h5a, 16'h0000);
    event_enable = 32'h0;
  endtask
  task automatic t_clash();
    p[14] = 1'b1;
    wr(8'h58, 16'h4000);
    p = 32'h0;
    wr(8'h58, 16'hbfff);
    rd(8'h58, 16'h4000);
    wr(8'h58, 16'h4000);
  endtask
  task automatic t_xfer();
    receive_transfer_count = 12'h003;
    receive_transfer_load = 1'b1;
    @(negedge mclk);
    receive_transfer_load = 1'b0;
    receive_unit_taken = 1'b1;
    repeat (2) @(negedge mclk);
    receive_unit_taken = 1'b0;
    rd(8'h5a, 16'h0000);
    receive_unit_taken = 1'b1;
    @(negedge mclk);
    receive_unit_taken = 1'b0;
    repeat (2) @(negedge mclk);
    rd(8'h5a, 16'h0010);
    wr(8'h5a, 16'h0010);
  endtask
  task automatic t_wake();
    low_power_active = 1'b1;
    event_enable[17] = 1'b1;
    p[17] = 1'b1;
    @(negedge mclk);
    p = 32'h0;
    chk("wake_request", 16'h0000, {15'h0, wake_request});
    chk("direct output", 16'h0001, {15'h0, power_event_direct});
    rd(8'h5a, 16'h0002);
    wr(8'h64, 16'h1234);
    chk("wake_request", 16'h0001, {15'h0, wake_request});
    wr(8'h66, 16'h0000);
    chk("wake_request", 16'h0001, {15'h0, wake_request});
    low_power_active = 1'b0;
    wr(8'h5a, 16'h0002);
    rd(8'h5a, 16'h0000);
    chk("wake_request", 16'h0000, {15'h0, wake_request});
    chk("direct output", 16'h0000, {15'h0, power_event_direct});
    event_enable = 32'h0;
  endtask
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    p = 32'h0;
    q = 1'b1;
    event_enable = 32'h0;
    physical_layer_event = 1'b0;
    low_power_active = 1'b0;
    receive_transfer_load = 1'b0;
    receive_unit_taken = 1'b0;
    receive_transfer_count = 12'h000;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_misc();
    t_sources();
    t_clash();
    t_xfer();
    t_wake();
    close_out();
  end
endmodule
